// *** include/dac_port_pkg.sv ***
package dac_port_pkg;
  // ----------------------------------------
  // Serial configuration command format
  // ----------------------------------------
  localparam int CMD_RW_BIT = 7;
  localparam logic [6:0] ADDR_LAST = 7'h1F;
  localparam logic [4:0] LOW5_LAST = 5'h1F;
  // ----------------------------------------
  // Configuration register addresses and bits
  // ----------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h01;
  localparam logic [4:0] REG_CLKOUT = 5'h02;
  localparam logic [4:0] REG_PORTS = 5'h03;
  localparam logic [4:0] REG_SPARE_RST = 5'h08;
  localparam logic [4:0] REG_TEST_SEL = 5'h18;
  localparam logic [4:0] REG_TEST_VAL = 5'h19;
  localparam logic [7:0] RST_VAL = 8'h00;
  localparam logic [7:0] RST_VAL_08 = 8'h08;
  localparam int CTRL_SW_RST = 0;
  localparam int CTRL_FULL_PD = 1;
  localparam int CLKOUT_HALF = 0;
  localparam int CLKOUT_CUR7 = 1;
  localparam int CLKOUT_TERM = 2;
  localparam int PORTS_DUAL = 0;
  localparam logic [15:0] SIGN_FLIP = 16'h8000;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int SCK_MAX_MHZ = 50;
  localparam int SCK_HALF_MIN = (CLK_MHZ + 2 * SCK_MAX_MHZ - 1) / (2 * SCK_MAX_MHZ);
  // ----------------------------------------
  // Controller APB map
  // ----------------------------------------
  localparam logic [7:0] APB_CTRL = 8'h00;
  localparam logic [7:0] APB_SPI_CMD = 8'h04;
  localparam logic [7:0] APB_STATUS = 8'h08;
  localparam logic [7:0] APB_SPI_RD = 8'h0C;
  localparam logic [7:0] APB_FIFO = 8'h10;
  localparam int FIFO_DEPTH = 32;
endpackage

// *** include/dac_link_if.sv ***
`timescale 1ns/10ps
interface dac_link_if #(parameter int W = 16);
  logic cs_n;
  logic sck;
  logic sdi;
  logic sdo_out;
  logic sdo_oe;
  wire sdo;
  logic power_down_n;
  logic [W-1:0] port_a_data;
  logic [W-1:0] port_b_data;
  logic data_clock_in;
  logic data_clock_out;
  // Released serial output reads as low, standing in for a weak pull-down.
  assign sdo = sdo_oe ? sdo_out : 1'b0;
  modport dev (input cs_n, sck, sdi, power_down_n, port_a_data, port_b_data, data_clock_in,
               output sdo_out, sdo_oe, data_clock_out);
  modport host (output cs_n, sck, sdi, power_down_n, port_a_data, port_b_data, data_clock_in,
                input sdo, data_clock_out);
endinterface

// *** rtl/dac_port_dev.sv ***
`timescale 1ns/10ps
module dac_port_dev #(
  parameter int W = 16
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  dac_link_if.dev link,
  output logic [W-1:0] analog_level_o,
  output logic analog_valid_o,
  output logic powered_o,
  output logic clkout_cur7_o,
  output logic clkout_term_o,
  output logic test_output_o
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [5:0] s1_r;
  logic [5:0] s2_r;
  logic [W-1:0] a1_r, a2_r, b1_r, b2_r;
  logic sck_d_r, dck_d_r, cs_d_r;
  // Every pin passes two flops; data shares the data clock's delay so edges stay aligned.
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
    begin
      s1_r <= 6'h01;
      s2_r <= 6'h01;
      a1_r <= '0;
      a2_r <= '0;
      b1_r <= '0;
      b2_r <= '0;
    end
    else
    begin
      s1_r <= {link.power_down_n, link.data_clock_in, link.sdi, link.sck, 1'b0, link.cs_n};
      s2_r <= s1_r;
      a1_r <= link.port_a_data;
      a2_r <= a1_r;
      b1_r <= link.port_b_data;
      b2_r <= b1_r;
    end
  wire cs_n_s = s2_r[0];
  wire sck_s = s2_r[2];
  wire sdi_s = s2_r[3];
  wire dck_s = s2_r[4];
  wire pd_n_s = s2_r[5];
  wire sck_rise = sck_s & ~sck_d_r & ~cs_n_s;
  wire sck_fall = ~sck_s & sck_d_r & ~cs_n_s;
  wire cs_rise = cs_n_s & ~cs_d_r;
  wire cs_fall = ~cs_n_s & cs_d_r;
  wire dck_edge = dck_s ^ dck_d_r;
  // ----------------------------------------
  // Serial framing
  // ----------------------------------------
  logic [7:0] regs_r [32];
  logic [2:0] bit_r;
  logic [6:0] in_sh_r;
  logic cmd_done_r, rd_r;
  logic [6:0] addr_r;
  logic [7:0] out_sh_r;
  logic sdo_r;
  wire [7:0] in_byte = {in_sh_r, sdi_s};
  wire byte_end = sck_rise & (bit_r == 3'h7);
  wire addr_ok = (addr_r[6:5] == 2'b00);
  localparam logic [4:0] LOW5_LAST_W = dac_port_pkg::LOW5_LAST;
  localparam int CMD_RW = dac_port_pkg::CMD_RW_BIT;
  wire [6:0] addr_nxt = (addr_r[4:0] == LOW5_LAST_W) ? addr_r : addr_r + 7'h01;
  wire [6:0] cmd_addr = in_byte[6:0];
  wire cmd_addr_ok = (cmd_addr[6:5] == 2'b00);
  wire [7:0] cmd_rd_val = cmd_addr_ok ? regs_r[cmd_addr[4:0]] : 8'h00;
  wire [7:0] nxt_rd_val = (addr_nxt[6:5] == 2'b00) ? regs_r[addr_nxt[4:0]] : 8'h00;
  wire wr_now = byte_end & cmd_done_r & ~rd_r & addr_ok;
  wire sw_rst = cs_rise & regs_r[dac_port_pkg::REG_CTRL][dac_port_pkg::CTRL_SW_RST];
  // Bit counter and command decode; a fresh chip select drops any partial byte.
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
    begin
      bit_r <= 3'h0;
      in_sh_r <= 7'h00;
      cmd_done_r <= 1'b0;
      rd_r <= 1'b0;
      addr_r <= 7'h00;
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
      dck_d_r <= 1'b0;
    end
    else
    begin
      sck_d_r <= sck_s;
      cs_d_r <= cs_n_s;
      dck_d_r <= dck_s;
      if (cs_fall || cs_n_s)
      begin
        bit_r <= 3'h0;
        cmd_done_r <= 1'b0;
      end
      else if (sck_rise)
      begin
        bit_r <= bit_r + 3'h1;
        in_sh_r <= in_byte[6:0];
        if (byte_end && !cmd_done_r)
        begin
          cmd_done_r <= 1'b1;
          rd_r <= in_byte[CMD_RW];
          addr_r <= cmd_addr;
        end
        else if (byte_end)
          addr_r <= addr_nxt;
      end
    end
  // Serial output: loaded on the byte's last rising edge, driven out on falling edges.
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
    begin
      out_sh_r <= 8'h00;
      sdo_r <= 1'b0;
    end
    else if (cs_n_s)
    begin
      out_sh_r <= 8'h00;
      sdo_r <= 1'b0;
    end
    else
    begin
      if (byte_end && !cmd_done_r)
        out_sh_r <= in_byte[CMD_RW] ? cmd_rd_val : 8'h00;
      else if (byte_end)
        out_sh_r <= rd_r ? nxt_rd_val : 8'h00;
      else if (sck_fall)
      begin
        sdo_r <= cmd_done_r & rd_r & out_sh_r[7];
        out_sh_r <= {out_sh_r[6:0], 1'b0};
      end
    end
  assign link.sdo_out = sdo_r;
  assign link.sdo_oe = ~cs_n_s;
  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // One generate iteration per register; software reset acts when chip select returns high.
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++)
    begin : g_reg
      localparam logic [7:0] RV = (gi == 32'(dac_port_pkg::REG_SPARE_RST)) ?
        dac_port_pkg::RST_VAL_08 : dac_port_pkg::RST_VAL;
      always_ff @(posedge clock_i or negedge nrst_i)
        if (!nrst_i)
          regs_r[gi] <= RV;
        else if (sw_rst)
          regs_r[gi] <= RV;
        else if (cs_rise && gi == 32'(dac_port_pkg::REG_CTRL))
          regs_r[gi] <= regs_r[gi] & ~8'h01;
        else if (wr_now && addr_r[4:0] == 5'(gi))
          regs_r[gi] <= in_byte;
    end
  endgenerate
  wire [7:0] ctrl = regs_r[dac_port_pkg::REG_CTRL];
  wire [7:0] clko = regs_r[dac_port_pkg::REG_CLKOUT];
  wire dual = regs_r[dac_port_pkg::REG_PORTS][dac_port_pkg::PORTS_DUAL];
  wire powered = pd_n_s & ~ctrl[dac_port_pkg::CTRL_FULL_PD];
  // ----------------------------------------
  // Sample path
  // ----------------------------------------
  logic [W-1:0] code_r, b_hold_r, level_r;
  logic b_pend_r, valid_r, valid_out_r;
  // In dual mode each data clock edge carries one sample per port; the B half waits one sample clock.
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
    begin
      code_r <= '0;
      b_hold_r <= '0;
      b_pend_r <= 1'b0;
      valid_r <= 1'b0;
    end
    else
    begin
      b_pend_r <= 1'b0;
      valid_r <= 1'b0;
      if (!powered)
        code_r <= '0;
      else if (b_pend_r)
      begin
        code_r <= b_hold_r;
        valid_r <= 1'b1;
      end
      else if (dck_edge && dual)
      begin
        code_r <= a2_r;
        b_hold_r <= b2_r;
        b_pend_r <= 1'b1;
        valid_r <= 1'b1;
      end
      else if (dck_edge)
      begin
        code_r <= b2_r;
        valid_r <= 1'b1;
      end
    end
  // Two's complement to offset level: zero lands at mid-scale.
  // Valid takes the same extra stage, so a user never pairs the pulse with a stale level.
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
    begin
      level_r <= W'(dac_port_pkg::SIGN_FLIP);
      valid_out_r <= 1'b0;
    end
    else
    begin
      level_r <= code_r ^ W'(dac_port_pkg::SIGN_FLIP);
      valid_out_r <= valid_r;
    end
  assign analog_level_o = level_r;
  assign analog_valid_o = valid_out_r;
  assign powered_o = powered;
  // ----------------------------------------
  // Divided clock out and test output
  // ----------------------------------------
  logic [1:0] div_r;
  logic test_r;
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
      div_r <= 2'h0;
    else
      div_r <= powered ? div_r + 2'h1 : 2'h0;
  assign link.data_clock_out = clko[dac_port_pkg::CLKOUT_HALF] ? div_r[0] : div_r[1];
  assign clkout_cur7_o = clko[dac_port_pkg::CLKOUT_CUR7];
  assign clkout_term_o = clko[dac_port_pkg::CLKOUT_TERM];
  wire [7:0] tsel = regs_r[dac_port_pkg::REG_TEST_SEL];
  wire [3:0] tsrc = {regs_r[dac_port_pkg::REG_TEST_VAL][0], valid_r, link.data_clock_out, 1'b0};
  // Registered so the pin never glitches when the selection changes.
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
      test_r <= 1'b0;
    else
      test_r <= tsrc[tsel[1:0]];
  assign test_output_o = test_r;
endmodule // dac_port_dev

// *** rtl/dac_port_host.sv ***
`timescale 1ns/10ps
module dac_word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic full_o,
  output logic empty_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r, rp_r;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;
  assign full_o = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign empty_o = (wp_r == rp_r);
  assign in_ready_o = ~full_o;
  assign out_valid_o = ~empty_o;
  assign out_data_o = mem[rp_r[AW-1:0]];
  // Extra pointer bit separates full from empty.
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      wp_r <= wp_r + (AW+1)'(push);
      rp_r <= rp_r + (AW+1)'(pop);
    end
  always_ff @(posedge clock_i)
    if (push)
      mem[wp_r[AW-1:0]] <= in_data_i;
endmodule // dac_word_fifo

module dac_port_host #(
  parameter int W = 16,
  parameter int SCK_HALF = 4
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  dac_link_if.host link
);
  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic dual_r, pd_n_r, busy_r;
  logic [7:0] rd_byte_r;
  logic [15:0] cmd_r;
  logic f_full, f_empty, f_ready, f_ovalid, f_pop;
  logic [31:0] f_odata;
  wire acc = psel & penable;
  wire hit_ctrl = paddr == dac_port_pkg::APB_CTRL;
  wire hit_cmd = paddr == dac_port_pkg::APB_SPI_CMD;
  wire hit_stat = paddr == dac_port_pkg::APB_STATUS;
  wire hit_rd = paddr == dac_port_pkg::APB_SPI_RD;
  wire hit_fifo = paddr == dac_port_pkg::APB_FIFO;
  wire hit_any = hit_ctrl | hit_cmd | hit_stat | hit_rd | hit_fifo;
  // FIFO writes stall while full; a command write stalls while a transfer runs.
  assign pready = ~(pwrite & hit_fifo & ~f_ready) & ~(pwrite & hit_cmd & busy_r);
  assign pslverr = acc & ~hit_any;
  wire wr = acc & pready & pwrite;
  wire start = wr & hit_cmd;
  assign prdata = hit_ctrl ? {30'h0, pd_n_r, dual_r} :
                  hit_stat ? {29'h0, f_empty, f_full, busy_r} :
                  hit_rd ? {24'h0, rd_byte_r} : 32'h0;
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
    begin
      dual_r <= 1'b0;
      pd_n_r <= 1'b0;
    end
    else if (wr && hit_ctrl)
    begin
      dual_r <= pwdata[0];
      pd_n_r <= pwdata[1];
    end
  assign link.power_down_n = pd_n_r;
  // ----------------------------------------
  // Sample FIFO and data port pacing
  // ----------------------------------------
  dac_word_fifo #(.WIDTH(32), .DEPTH(dac_port_pkg::FIFO_DEPTH)) u_fifo (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .in_valid_i(wr & hit_fifo),
    .in_ready_o(f_ready),
    .in_data_i(pwdata),
    .out_valid_o(f_ovalid),
    .out_ready_i(f_pop),
    .out_data_o(f_odata),
    .full_o(f_full),
    .empty_o(f_empty)
  );
  logic pace_r, dck_r;
  logic [W-1:0] a_r, b_r;
  // Dual mode sends a word pair every second clock (data clock a quarter of the rate),
  // single mode every clock (half rate); the data clock only toggles when a word is sent.
  assign f_pop = f_ovalid & (~dual_r | pace_r);
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
    begin
      pace_r <= 1'b0;
      dck_r <= 1'b0;
      a_r <= '0;
      b_r <= '0;
    end
    else
    begin
      pace_r <= dual_r & ~pace_r;
      if (f_pop)
      begin
        dck_r <= ~dck_r;
        a_r <= dual_r ? f_odata[31:16] : '0;
        b_r <= f_odata[15:0];
      end
    end
  assign link.data_clock_in = dck_r;
  assign link.port_a_data = a_r;
  assign link.port_b_data = b_r;
  // ----------------------------------------
  // Serial engine
  // ----------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_LEAD, S_SHIFT, S_TAIL} spi_state_t;
  localparam int HALF = (SCK_HALF > dac_port_pkg::SCK_HALF_MIN) ? SCK_HALF : dac_port_pkg::SCK_HALF_MIN;
  spi_state_t st_r;
  logic [7:0] cnt_r;
  logic [4:0] nbit_r;
  logic sck_r, cs_n_r;
  logic [1:0] sdo1_r;
  wire half_done = cnt_r == 8'(HALF - 1);
  // Bits change while the clock is low and are read back on the falling edge.
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
    begin
      st_r <= S_IDLE;
      cnt_r <= 8'h00;
      nbit_r <= 5'h00;
      sck_r <= 1'b0;
      cs_n_r <= 1'b1;
      cmd_r <= 16'h0000;
      rd_byte_r <= 8'h00;
      busy_r <= 1'b0;
      sdo1_r <= 2'b00;
    end
    else
    begin
      sdo1_r <= {sdo1_r[0], link.sdo};
      cnt_r <= half_done ? 8'h00 : cnt_r + 8'h01;
      unique case (st_r)
        S_IDLE:
          if (start)
          begin
            cmd_r <= pwdata[15:0];
            busy_r <= 1'b1;
            cs_n_r <= 1'b0;
            cnt_r <= 8'h00;
            nbit_r <= 5'h00;
            st_r <= S_LEAD;
          end
        S_LEAD:
          if (half_done)
            st_r <= S_SHIFT;
        S_SHIFT:
          if (half_done && !sck_r)
            sck_r <= 1'b1;
          else if (half_done)
          begin
            sck_r <= 1'b0;
            rd_byte_r <= {rd_byte_r[6:0], sdo1_r[1]};
            cmd_r <= {cmd_r[14:0], 1'b0};
            nbit_r <= nbit_r + 5'h01;
            if (nbit_r == 5'h0F)
              st_r <= S_TAIL;
          end
        S_TAIL:
          if (half_done && !cs_n_r)
            cs_n_r <= 1'b1;
          else if (half_done)
          begin
            busy_r <= 1'b0;
            st_r <= S_IDLE;
          end
      endcase
    end
  assign link.cs_n = cs_n_r;
  assign link.sck = sck_r;
  assign link.sdi = cmd_r[15];
endmodule // dac_port_host

// *** tb/dac_link_properties.sv ***
`timescale 1ns/10ps
module dac_link_properties #(
  parameter int W = 16
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  input wire logic [W-1:0] port_b_data,
  input wire logic data_clock_in
);
  // ----------------------------------------
  // Link checks, one clock domain
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // The device sees its pins two cycles late, so release is judged after three.
  property p_release; cs_n [*3] |-> !sdo_oe; endproperty
  a_release: assert property (p_release) else $error("serial output driven while deselected");
  property p_enable; $fell(cs_n) |-> ##[1:4] sdo_oe; endproperty
  a_enable: assert property (p_enable) else $error("serial output not driven after select");
  property p_idle; $past(cs_n, 2) && $past(cs_n) && cs_n |-> !sck; endproperty
  a_idle: assert property (p_idle) else $error("serial clock runs while deselected");
  property p_sdi; $changed(sdi) |-> !sck; endproperty
  a_sdi: assert property (p_sdi) else $error("serial input changed while clock high");
  property p_sck_high; $rose(sck) |-> sck [*2]; endproperty
  a_sck_high: assert property (p_sck_high) else $error("serial clock high too short");
  property p_sck_low; $fell(sck) && !cs_n |-> !sck [*2]; endproperty
  a_sck_low: assert property (p_sck_low) else $error("serial clock low too short");
  property p_sdo; $changed(sdo_out) && sdo_oe && $past(sdo_oe) |-> !sck; endproperty
  a_sdo: assert property (p_sdo) else $error("serial output changed while clock high");
  property p_data; $changed(port_b_data) |-> $changed(data_clock_in); endproperty
  a_data: assert property (p_data) else $error("port data changed without clock edge");
  // Main traffic seen at least once.
  c_select: cover property ($fell(cs_n));
  c_drive: cover property ($rose(sdo_oe));
  c_data: cover property ($changed(data_clock_in));
endmodule // dac_link_properties

// *** tb/dac_data_and_config_port_tb.sv ***
`timescale 1ns/10ps
module dac_data_and_config_port_tb;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] level;
  logic valid;
  logic powered;
  logic cur7;
  logic term;
  logic tst;
  logic [31:0] rd;
  logic err;
  int n_errors = 0;
  int n_compared = 0;
  // A half period of 2.5 ns gives 200 MHz.
  always #2.5 clock_i = ~clock_i;
  dac_link_if #(.W(16)) link ();
  dac_port_host #(.W(16), .SCK_HALF(4)) u_dac_port_host (.clock_i(clock_i), .nrst_i(nrst_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  dac_port_dev #(.W(16)) u_dac_port_dev (.clock_i(clock_i), .nrst_i(nrst_i), .link(link),
    .analog_level_o(level), .analog_valid_o(valid), .powered_o(powered), .clkout_cur7_o(cur7),
    .clkout_term_o(term), .test_output_o(tst));
  dac_link_properties #(.W(16)) u_dac_link_properties (.clock_i(clock_i), .nrst_i(nrst_i), .cs_n(link.cs_n),
    .sck(link.sck), .sdi(link.sdi), .sdo_out(link.sdo_out), .sdo_oe(link.sdo_oe),
    .port_b_data(link.port_b_data), .data_clock_in(link.data_clock_in));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic hang();
    n_errors++;
    $display("unexpected wait expected done seen none");
    finish_test();
  endtask
  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    for (i = 0; i < 400; i++)
    begin
      @(posedge clock_i);
      if (pready === 1'b1) break;
    end
    if (i == 400) hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One serial transfer; the command byte sits above the data byte and goes out first.
  task automatic spi(input logic [7:0] cmd, input logic [7:0] dat);
    int i;
    apb(1'b1, dac_port_pkg::APB_SPI_CMD, {16'h0000, cmd, dat});
    for (i = 0; i < 100; i++)
    begin
      apb(1'b0, dac_port_pkg::APB_STATUS, 32'h00000000);
      if (rd[0] === 1'b0) break;
    end
    if (i == 100) hang();
    apb(1'b0, dac_port_pkg::APB_SPI_RD, 32'h00000000);
    repeat (4) @(posedge clock_i);
  endtask
  task automatic sample(input logic [15:0] exp, input int lim);
    int i;
    for (i = 0; i < lim; i++)
    begin
      @(posedge clock_i);
      if (valid === 1'b1) break;
    end
    if (i == lim) hang();
    cmp("level", 32'(exp), 32'(level));
  endtask
  task automatic toggles(input int exp);
    int n;
    logic last;
    n = 0;
    @(posedge clock_i);
    last = link.data_clock_out;
    repeat (8)
    begin
      @(posedge clock_i);
      if (link.data_clock_out !== last) n++;
      last = link.data_clock_out;
    end
    cmp("clock out toggles", 32'(exp), 32'(n));
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [7:0] ra [4] = '{8'h88, 8'h82, 8'h98, 8'h81};
    logic [7:0] rv [4] = '{8'h08, 8'h00, 8'h00, 8'h00};
    apb(1'b0, dac_port_pkg::APB_STATUS, 32'h00000000);
    cmp("status", 32'h00000004, 32'(rd[2:0]));
    foreach (ra[k])
    begin
      spi(ra[k], 8'hFF);
      cmp("reset value", 32'(rv[k]), 32'(rd[7:0]));
    end
  endtask
  task automatic t_regs();
    spi(8'h19, 8'h01);
    spi(8'h18, 8'h03);
    cmp("test output", 32'h00000001, 32'(tst));
    spi(8'h98, 8'h00);
    cmp("read back", 32'h00000003, 32'(rd[7:0]));
    spi(8'h19, 8'h00);
    cmp("test output", 32'h00000000, 32'(tst));
    spi(8'h25, 8'hFF);
    spi(8'hA5, 8'h00);
    cmp("unmapped reg", 32'h00000000, 32'(rd[7:0]));
  endtask
  // The host grounds port A in single mode; the last word runs the host in dual mode
  // so that port A carries junk, which the device in single mode must ignore.
  task automatic t_single();
    apb(1'b1, dac_port_pkg::APB_CTRL, 32'h00000002);
    repeat (6) @(posedge clock_i);
    cmp("powered", 32'h00000001, 32'(powered));
    apb(1'b1, dac_port_pkg::APB_FIFO, 32'hFFFF0000);
    sample(16'h8000, 60);
    cmp("port a", 32'h00000000, 32'(link.port_a_data));
    apb(1'b1, dac_port_pkg::APB_FIFO, 32'h00007FFF);
    sample(16'hFFFF, 60);
    apb(1'b1, dac_port_pkg::APB_FIFO, 32'h00008000);
    sample(16'h0000, 60);
    apb(1'b1, dac_port_pkg::APB_CTRL, 32'h00000003);
    apb(1'b1, dac_port_pkg::APB_FIFO, 32'hFFFF1234);
    sample(16'h9234, 60);
  endtask
  task automatic t_clkout();
    spi(8'h02, 8'h07);
    cmp("current", 32'h00000001, 32'(cur7));
    cmp("termination", 32'h00000001, 32'(term));
    toggles(8);
    spi(8'h02, 8'h00);
    toggles(4);
  endtask
  // Port B must follow port A on the very next cycle.
  task automatic t_dual();
    spi(8'h03, 8'h01);
    apb(1'b1, dac_port_pkg::APB_CTRL, 32'h00000003);
    apb(1'b1, dac_port_pkg::APB_FIFO, 32'h1234FEDC);
    sample(16'h9234, 60);
    sample(16'h7EDC, 1);
  endtask
  task automatic t_power();
    spi(8'h01, 8'h02);
    cmp("full power down", 32'h00000000, 32'(powered));
    spi(8'h01, 8'h00);
    apb(1'b1, dac_port_pkg::APB_CTRL, 32'h00000001);
    repeat (6) @(posedge clock_i);
    cmp("powered", 32'h00000000, 32'(powered));
    cmp("idle level", 32'h00008000, 32'(level));
  endtask
  // Software reset: the control bit clears itself and every register returns to its reset value.
  task automatic t_sw_reset();
    spi(8'h01, 8'h01);
    spi(8'h98, 8'h00);
    cmp("soft reset value", 32'h00000000, 32'(rd[7:0]));
    spi(8'h88, 8'h00);
    cmp("soft reset value", 32'h00000008, 32'(rd[7:0]));
    spi(8'h81, 8'h00);
    cmp("reset bit", 32'h00000000, 32'(rd[7:0]));
  endtask
  task automatic t_apb_err();
    apb(1'b0, 8'hFC, 32'h00000000);
    cmp("slave error", 32'h00000001, 32'(err));
    cmp("unmapped data", 32'h00000000, rd);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge clock_i);
    nrst_i <= 1'b1;
    t_reset();
    t_regs();
    t_single();
    t_clkout();
    t_dual();
    t_power();
    t_sw_reset();
    t_apb_err();
    finish_test();
  end
endmodule // dac_data_and_config_port_tb
